// File: core/ctm_core.sv
// Purpose: Mode, transmit, receive and protection control of a CAN
//          transceiver, with APB status, control and interrupt registers.
// Assumes: Analog comparators deliver synchronous digital indications.
// Notes:   Decisions are registered, so pins lag inputs by one cycle.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ctm_core
   import ctm_pkg::*;
#(
   // Benches may shorten the dominant timeout; silicon keeps the default.
   parameter int unsigned DOM_LIMIT_CYC = DOM_TIMEOUT_CYC
)
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Controller side
   input  wire logic        txd_in,
   output logic             rxd_out,
   // Mode pins
   input  wire logic [1:0]  mode_select_in,
   input  wire logic        low_power_select_in,
   input  wire logic        silent_in,
   // Analog indications
   input  wire logic        bus_diff_above_in,
   input  wire logic        wake_diff_above_in,
   input  wire logic        over_temp_in,
   input  wire logic        temp_below_hyst_in,
   input  wire logic        short_detect_in,
   // Bus driver controls and interrupt
   output logic             drive_dominant_out,
   output logic             current_limit_out,
   output logic             split_drive_out,
   output logic             slope_mode_out,
   output logic             standby_out,
   output logic             irq_out
);

   logic [31:0]      ctrl_reg;
   logic [IRQ_W-1:0] irq_st_reg;
   logic [IRQ_W-1:0] irq_en_reg;
   logic [CNT_W-1:0] dom_cnt_reg;
   logic [CNT_W-1:0] wake_cnt_reg;
   logic             txd_prev_reg;
   logic             timeout_reg;
   logic             thermal_reg;
   logic             short_prev_reg;
   logic             woke_reg;

   // Mode decode: mode_select_in carries the comparator result of the pin.
   wire ctm_mode_type pin_mode =
      (mode_select_in == 2'b00) ? MODE_HIGH_SPEED :
      (mode_select_in == 2'b01) ? MODE_SLOPE : MODE_STANDBY;
   wire use_low_power_select_in  = ctrl_reg[CTRL_USE_LOW_POWER_SELECT_IN];
   wire standby   = use_low_power_select_in ? (low_power_select_in |
                    ctrl_reg[CTRL_LOWPWR_SEL]) :
                    (pin_mode == MODE_STANDBY);
   wire slope     = !use_low_power_select_in && (pin_mode == MODE_SLOPE);
   wire silent    = silent_in | ctrl_reg[CTRL_SILENT];
   wire txd_rise  = txd_in && !txd_prev_reg;
   wire dom_full  = (dom_cnt_reg == CNT_W'(DOM_LIMIT_CYC - 1));
   wire wake_full = (wake_cnt_reg == CNT_W'(WAKE_FILTER_CYC - 1));
   wire tx_allow  = !standby && !silent && !timeout_reg &&
                    !thermal_reg && !over_temp_in;
   wire timeout_set = !txd_in && dom_full;
   wire thermal_clr = temp_below_hyst_in && txd_rise;
   wire short_fall  = short_prev_reg && !short_detect_in;
   wire wake_set    = standby && wake_diff_above_in && wake_full;
   wire [IRQ_W-1:0] irq_evt = {wake_set && !woke_reg,
                               short_detect_in && !short_prev_reg,
                               over_temp_in && !thermal_reg,
                               timeout_set && !timeout_reg};

   // APB decode: zero wait states; unmapped addresses answer with an error.
   wire apb_acc   = psel_in && penable_in;
   wire apb_wr    = apb_acc && pwrite_in;
   wire hit_ctrl  = paddr_in == ADDR_CTRL;
   wire hit_stat  = paddr_in == ADDR_STATUS;
   wire hit_ist   = paddr_in == ADDR_IRQ_ST;
   wire hit_ien   = paddr_in == ADDR_IRQ_EN;
   wire hit_iclr  = paddr_in == ADDR_IRQ_CLR;
   wire mapped    = hit_ctrl | hit_stat | hit_ist | hit_ien | hit_iclr;
   wire [31:0] status_word = {22'h0, standby, slope, silent, woke_reg,
                              short_detect_in, thermal_reg, timeout_reg,
                              txd_in, bus_diff_above_in, tx_allow};
   wire [31:0] rd_word =
      hit_ctrl ? ctrl_reg :
      hit_stat ? status_word :
      hit_ist  ? {28'h0, irq_st_reg} :
      hit_ien  ? {28'h0, irq_en_reg} : 32'h0;
   wire [IRQ_W-1:0] clr_mask =
      (apb_wr && hit_iclr) ? pwdata_in[IRQ_W-1:0] : '0;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_reg    <= CTRL_RESET;
         irq_en_reg  <= '0;
         prdata_out  <= 32'h0;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         if (apb_wr && hit_ctrl) begin
            ctrl_reg <= {29'h0, pwdata_in[2:0]};
         end
         if (apb_wr && hit_ien) begin
            irq_en_reg <= pwdata_in[IRQ_W-1:0];
         end
         pready_out  <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !mapped;
         prdata_out  <= (psel_in && !penable_in && !pwrite_in) ?
                        rd_word : 32'h0;
      end
   end

   // Set wins over a clear landing in the same cycle.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_st_reg <= '0;
         irq_out    <= 1'b0;
      end else begin
         irq_st_reg <= (irq_st_reg & ~clr_mask) | irq_evt;
         irq_out    <= |(((irq_st_reg & ~clr_mask) | irq_evt) &
                         irq_en_reg);
      end
   end

   // Dominant timeout counter runs only while transmit data is low.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         dom_cnt_reg  <= '0;
         txd_prev_reg <= 1'b1;
         timeout_reg  <= 1'b0;
      end else begin
         txd_prev_reg <= txd_in;
         dom_cnt_reg  <= (txd_in || dom_full) ? '0 :
                         dom_cnt_reg + 1'b1;
         if (timeout_set) begin
            timeout_reg <= 1'b1;
         end else if (txd_rise) begin
            timeout_reg <= 1'b0;
         end
      end
   end

   // Thermal latch holds until cool and a rising edge arrives together.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         thermal_reg    <= 1'b0;
         short_prev_reg <= 1'b0;
      end else begin
         short_prev_reg <= short_detect_in;
         if (over_temp_in) begin
            thermal_reg <= 1'b1;
         end else if (thermal_clr) begin
            thermal_reg <= 1'b0;
         end
      end
   end

   // Wake filter: dominant must persist across the whole filter window.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         wake_cnt_reg <= '0;
         woke_reg     <= 1'b0;
      end else begin
         wake_cnt_reg <= (!standby || !wake_diff_above_in) ? '0 :
                         (wake_full ? wake_cnt_reg :
                          wake_cnt_reg + 1'b1);
         if (!standby) begin
            woke_reg <= 1'b0;
         end else if (wake_set) begin
            woke_reg <= 1'b1;
         end
      end
   end

   // Outputs; short_fall only documents that the limit clears by itself.
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         drive_dominant_out <= 1'b0;
         current_limit_out  <= 1'b0;
         split_drive_out    <= 1'b0;
         slope_mode_out     <= 1'b0;
         standby_out        <= 1'b0;
         rxd_out            <= 1'b1;
      end else begin
         drive_dominant_out <= tx_allow && !txd_in && !timeout_set;
         current_limit_out  <= short_detect_in && !short_fall;
         split_drive_out    <= !standby;
         slope_mode_out     <= slope;
         standby_out        <= standby;
         rxd_out            <= standby ? !(wake_set || woke_reg) :
                               !bus_diff_above_in;
      end
   end

   property p_silent_recessive;
      @(posedge mclk_in) disable iff (rst_in)
      (silent_in || standby) |=> !drive_dominant_out;
   endproperty
   a_silent_recessive: assert property (p_silent_recessive)
      else $error("transmitter active in silent or standby");

   property p_tx_follow;
      @(posedge mclk_in) disable iff (rst_in)
      (tx_allow && !txd_in && !timeout_set) |=> drive_dominant_out;
   endproperty
   a_tx_follow: assert property (p_tx_follow)
      else $error("enabled low transmit data did not drive dominant");

   property p_timeout_release;
      @(posedge mclk_in) disable iff (rst_in)
      timeout_set |=> (timeout_reg && !drive_dominant_out);
   endproperty
   a_timeout_release: assert property (p_timeout_release)
      else $error("dominant timeout did not release the bus");

   sequence s_timed_out;
      timeout_reg && !txd_rise;
   endsequence
   property p_timeout_hold;
      @(posedge mclk_in) disable iff (rst_in)
      s_timed_out ##0 !txd_in |=> timeout_reg;
   endproperty
   a_timeout_hold: assert property (p_timeout_hold)
      else $error("timeout cleared without a rising edge");

   property p_rx_normal;
      @(posedge mclk_in) disable iff (rst_in)
      !standby |=> (rxd_out == !$past(bus_diff_above_in));
   endproperty
   a_rx_normal: assert property (p_rx_normal)
      else $error("receive data does not follow the bus");

   property p_thermal_hold;
      @(posedge mclk_in) disable iff (rst_in)
      (thermal_reg && !over_temp_in && !thermal_clr) |=> thermal_reg;
   endproperty
   a_thermal_hold: assert property (p_thermal_hold)
      else $error("thermal latch left without cool edge");

   property p_split;
      @(posedge mclk_in) disable iff (rst_in)
      standby |=> !split_drive_out;
   endproperty
   a_split: assert property (p_split)
      else $error("split driven in standby");

   property p_wake;
      @(posedge mclk_in) disable iff (rst_in)
      (standby && !woke_reg && !wake_diff_above_in) ##1
      (standby && wake_diff_above_in)[*2] |-> rxd_out;
   endproperty
   a_wake: assert property (p_wake)
      else $error("receive data left high level too early in standby");

   property p_mode_slope;
      @(posedge mclk_in) disable iff (rst_in)
      (!use_low_power_select_in && mode_select_in == 2'b01) |=>
         (slope_mode_out && !standby_out);
   endproperty
   a_mode_slope: assert property (p_mode_slope)
      else $error("slope select did not give slope control");

   property p_low_power_select_in_pin;
      @(posedge mclk_in) disable iff (rst_in)
      (use_low_power_select_in && low_power_select_in) |=>
         (standby_out && !slope_mode_out);
   endproperty
   a_low_power_select_in_pin: assert property (p_low_power_select_in_pin)
      else $error("standby select input ignored");

   sequence s_rearm;
      timeout_reg && txd_rise;
   endsequence
   property p_timeout_rearm;
      @(posedge mclk_in) disable iff (rst_in)
      s_rearm |=> !timeout_reg;
   endproperty
   a_timeout_rearm: assert property (p_timeout_rearm)
      else $error("rising edge did not re-enable the transmitter");

   property p_thermal_off;
      @(posedge mclk_in) disable iff (rst_in)
      over_temp_in |=> (thermal_reg && !drive_dominant_out);
   endproperty
   a_thermal_off: assert property (p_thermal_off)
      else $error("driver left on above the temperature limit");

   property p_thermal_resume;
      @(posedge mclk_in) disable iff (rst_in)
      (thermal_reg && !over_temp_in && thermal_clr) |=> !thermal_reg;
   endproperty
   a_thermal_resume: assert property (p_thermal_resume)
      else $error("thermal latch kept after cool rising edge");

   property p_short_limit;
      @(posedge mclk_in) disable iff (rst_in)
      1'b1 |=> (current_limit_out == $past(short_detect_in));
   endproperty
   a_short_limit: assert property (p_short_limit)
      else $error("current limit does not track the short");

   property p_standby_quiet;
      @(posedge mclk_in) disable iff (rst_in)
      standby |=> (standby_out && !drive_dominant_out);
   endproperty
   a_standby_quiet: assert property (p_standby_quiet)
      else $error("bus driven while in standby");

   property p_wake_low;
      @(posedge mclk_in) disable iff (rst_in)
      wake_set |=> !rxd_out;
   endproperty
   a_wake_low: assert property (p_wake_low)
      else $error("filtered wake-up did not pull receive data low");

   property p_irq_level;
      @(posedge mclk_in) disable iff (rst_in)
      1'b1 |=> (irq_out == |(irq_st_reg & $past(irq_en_reg)));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt output disagrees with enabled status");

   property p_apb_ready;
      @(posedge mclk_in) disable iff (rst_in)
      (psel_in && !penable_in) |=> pready_out;
   endproperty
   a_apb_ready: assert property (p_apb_ready)
      else $error("setup cycle not answered in the next cycle");

endmodule : ctm_core

// File: inc/ctm_pkg.sv
// Purpose: Shared constants for the CAN transceiver mode control block.
// Assumes: 125 MHz mclk_in, APB register access with 32-bit data.
// Notes:   Analog levels arrive as already-decided digital indications.
package ctm_pkg;
   localparam int unsigned CLK_MHZ         = 125;
   localparam int unsigned DOM_TIMEOUT_US  = 1000;
   localparam int unsigned DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned WAKE_FILTER_NS  = 500;
   localparam int unsigned WAKE_FILTER_CYC =
      (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W           = 18;

   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN  = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;

   localparam int unsigned CTRL_LOWPWR_SEL = 0;
   localparam int unsigned CTRL_SILENT     = 1;
   localparam int unsigned CTRL_USE_LOW_POWER_SELECT_IN   = 2;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

   localparam int unsigned IRQ_W        = 4;
   localparam int unsigned IRQ_TIMEOUT  = 0;
   localparam int unsigned IRQ_THERMAL  = 1;
   localparam int unsigned IRQ_SHORT    = 2;
   localparam int unsigned IRQ_WAKE     = 3;

   typedef enum logic [1:0] {
      MODE_HIGH_SPEED = 2'b00,
      MODE_SLOPE      = 2'b01,
      MODE_STANDBY    = 2'b10
   } ctm_mode_type;
endpackage : ctm_pkg

// File: tb/ctm_bus_model.sv
// Purpose: Stand-in for the bus pair and the other nodes on it.
// Assumes: A dominant level from any node wins over recessive.
// Notes:   An undriven pair reads recessive, as a terminated bus does.
`timescale 1ns/1ps
module ctm_bus_model (
   // Driver side
   input  wire logic drive_dominant_in,
   input  wire logic other_dom_in,
   // Comparator side
   output logic      bus_diff_above_out,
   output logic      wake_diff_above_out
);
   assign bus_diff_above_out  = drive_dominant_in | other_dom_in;
   assign wake_diff_above_out = drive_dominant_in | other_dom_in;
endmodule : ctm_bus_model

// File: tb/tb.sv
// Purpose: Self-checking bench for the CAN transceiver control block.
// Assumes: Pins lag inputs one cycle; rxd lags two through the bus.
// Notes:   The dominant timeout is shortened by parameter to keep runs brief.
`timescale 1ns/1ps
module tb;
   import ctm_pkg::*;
   localparam int unsigned TB_DOM_CYC = 2000;
   logic        mclk_in, pready_out, pslverr_out, rxd_out, irq_out;
   logic        rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
   logic        pwrite_in = 1'b0, txd_in = 1'b1, silent_in = 1'b0;
   logic        low_power_select_in = 1'b0, over_temp_in = 1'b0;
   logic        temp_below_hyst_in = 1'b1, short_detect_in = 1'b0;
   logic        other_dom = 1'b0, pin_stb = 1'b0, t, o;
   logic        bus_diff_above_in, wake_diff_above_in, drive_dominant_out;
   logic        current_limit_out, split_drive_out, slope_mode_out;
   logic        standby_out;
   logic [1:0]  mode_select_in = 2'h0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out;
   logic [32:0] rd_q[$];
   logic [6:0]  pin_q[$];
   int          err_count = 0, num_checks = 0, seed = 2625;

   ctm_core #(.DOM_LIMIT_CYC(TB_DOM_CYC)) dut_u (.mclk_in, .rst_in,
      .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
      .txd_in, .rxd_out, .mode_select_in, .low_power_select_in,
      .silent_in, .bus_diff_above_in, .wake_diff_above_in, .over_temp_in,
      .temp_below_hyst_in, .short_detect_in, .drive_dominant_out,
      .current_limit_out, .split_drive_out, .slope_mode_out, .standby_out,
      .irq_out);
   ctm_bus_model bus_u (.drive_dominant_in(drive_dominant_out),
      .other_dom_in(other_dom), .bus_diff_above_out(bus_diff_above_in),
      .wake_diff_above_out(wake_diff_above_in));

   initial begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   // Read results are judged at the edge that completes the access.
   always @(posedge mclk_in)
      if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in)
         check({pslverr_out, prdata_out}, rd_q.pop_front());
   always @(negedge mclk_in)
      if (pin_stb)
         check({26'h0, rxd_out, drive_dominant_out, split_drive_out,
                slope_mode_out, standby_out, current_limit_out, irq_out},
               {26'h0, pin_q.pop_front()});

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      if (!w)
         rd_q.push_back(e);
      psel_in   <= 1'b1;
      pwrite_in <= w;
      paddr_in  <= a;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      do @(posedge mclk_in); while (pready_out !== 1'b1);
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      @(posedge mclk_in);
   endtask : apb

   // Two edges let rxd settle after the driver and the bus have moved.
   task automatic pins(input logic [6:0] e);
      repeat (2) @(posedge mclk_in);
      pin_q.push_back(e);
      pin_stb <= 1'b1;
      @(posedge mclk_in);
      pin_stb <= 1'b0;
   endtask : pins

   function automatic logic [6:0] pv(input logic r, d, s, sl, sb, c, i);
      return {r, d, s, sl, sb, c, i};
   endfunction : pv

   initial begin
      #(8 * 20000);
      err_count++;
      complete_run();
   end

   initial begin
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(posedge mclk_in);
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      apb(1'b0, ADDR_CTRL, 32'h0, {1'b0, CTRL_RESET});
      apb(1'b0, ADDR_IRQ_EN, 32'h0, 33'h0);
      apb(1'b0, 8'h14, 32'h0, 33'h1_0000_0000);
      apb(1'b1, ADDR_CTRL, 32'h4, 33'h0);
      apb(1'b0, ADDR_CTRL, 32'h0, 33'h4);
      low_power_select_in <= 1'b1;
      pins(pv(1, 0, 0, 0, 1, 0, 0));
      low_power_select_in <= 1'b0;
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      apb(1'b1, ADDR_CTRL, 32'h5, 33'h0);
      pins(pv(1, 0, 0, 0, 1, 0, 0));
      apb(1'b1, ADDR_CTRL, 32'h0, 33'h0);
      for (int m = 0; m < 4; m++) begin
         mode_select_in <= m[1:0];
         pins(pv(1, 0, m < 2, m == 1, m >= 2, 0, 0));
      end
      mode_select_in <= 2'h0;
      $display("done registers and modes");
      for (int i = 0; i < 16; i++) begin
         t = 1'($random(seed));
         o = 1'($random(seed));
         txd_in <= t;
         other_dom <= o;
         pins(pv(t & ~o, ~t, 1, 0, 0, 0, 0));
      end
      txd_in <= 1'b0;
      other_dom <= 1'b1;
      silent_in <= 1'b1;
      pins(pv(0, 0, 1, 0, 0, 0, 0));
      other_dom <= 1'b0;
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      silent_in <= 1'b0;
      pins(pv(0, 1, 1, 0, 0, 0, 0));
      apb(1'b0, ADDR_STATUS, 32'h0, 33'h3);
      apb(1'b1, ADDR_CTRL, 32'h2, 33'h0);
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      apb(1'b1, ADDR_CTRL, 32'h0, 33'h0);
      $display("done transmit, receive and silent");
      mode_select_in <= 2'h2;
      txd_in <= 1'b0;
      pins(pv(1, 0, 0, 0, 1, 0, 0));
      other_dom <= 1'b1;
      pins(pv(1, 0, 0, 0, 1, 0, 0));
      repeat (40) @(posedge mclk_in);
      pins(pv(1, 0, 0, 0, 1, 0, 0));
      repeat (30) @(posedge mclk_in);
      pins(pv(0, 0, 0, 0, 1, 0, 0));
      other_dom <= 1'b0;
      txd_in <= 1'b1;
      mode_select_in <= 2'h0;
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      apb(1'b0, ADDR_IRQ_ST, 32'h0, 33'h8);
      apb(1'b1, ADDR_IRQ_CLR, 32'hf, 33'h0);
      $display("done standby wake");
      apb(1'b1, ADDR_IRQ_EN, 32'h4, 33'h0);
      short_detect_in <= 1'b1;
      pins(pv(1, 0, 1, 0, 0, 1, 1));
      short_detect_in <= 1'b0;
      pins(pv(1, 0, 1, 0, 0, 0, 1));
      apb(1'b1, ADDR_IRQ_CLR, 32'h4, 33'h0);
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      $display("done short");
      txd_in <= 1'b0;
      over_temp_in <= 1'b1;
      temp_below_hyst_in <= 1'b0;
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      over_temp_in <= 1'b0;
      txd_in <= 1'b1;
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      txd_in <= 1'b0;
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      temp_below_hyst_in <= 1'b1;
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      txd_in <= 1'b1;
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      txd_in <= 1'b0;
      pins(pv(0, 1, 1, 0, 0, 0, 0));
      txd_in <= 1'b1;
      apb(1'b0, ADDR_IRQ_ST, 32'h0, 33'h2);
      apb(1'b1, ADDR_IRQ_CLR, 32'hf, 33'h0);
      $display("done thermal");
      txd_in <= 1'b0;
      repeat (TB_DOM_CYC - 100) @(posedge mclk_in);
      pins(pv(0, 1, 1, 0, 0, 0, 0));
      repeat (200) @(posedge mclk_in);
      pins(pv(1, 0, 1, 0, 0, 0, 0));
      apb(1'b0, ADDR_IRQ_ST, 32'h0, 33'h1);
      apb(1'b1, ADDR_IRQ_EN, 32'h1, 33'h0);
      pins(pv(1, 0, 1, 0, 0, 0, 1));
      txd_in <= 1'b1;
      pins(pv(1, 0, 1, 0, 0, 0, 1));
      apb(1'b1, ADDR_IRQ_CLR, 32'h1, 33'h0);
      txd_in <= 1'b0;
      pins(pv(0, 1, 1, 0, 0, 0, 0));
      txd_in <= 1'b1;
      $display("done dominant timeout");
      complete_run();
   end
endmodule : tb
